// ---- common/tfc_pkg.sv ----
// Constants, types and layout of the transport frame codec.
// Assumes a single 200 MHz byte clock.
package tfc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned FRAME_PERIOD_US = 24000;
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned FRAME_CYCLES    = FRAME_PERIOD_US * CLK_MHZ;

	// ----------------------------------------
	// Frame layout (position 0 is index -8)
	// ----------------------------------------
	localparam logic [15:0] FRAME_LEN_DEF = 16'h0300;
	localparam logic [15:0] HDR_LEN       = 16'h0008;
	localparam logic [2:0]  POS_FAULT     = 3'h0;
	localparam logic [2:0]  POS_MARK0     = 3'h1;
	localparam logic [2:0]  POS_MARK1     = 3'h2;
	localparam logic [2:0]  POS_MARK2     = 3'h3;
	localparam logic [2:0]  POS_DS_HI     = 3'h4;
	localparam logic [2:0]  POS_DS_LO     = 3'h5;
	localparam logic [2:0]  POS_CS_HI     = 3'h6;
	localparam logic [2:0]  POS_CS_LO     = 3'h7;
	localparam logic [23:0] MARKER_EVEN   = 24'h1f90ca;
	localparam logic [23:0] MARKER_ODD    = 24'he06f35;
	localparam logic [7:0]  PAD_BYTE      = 8'h55;

	// ----------------------------------------
	// Fault levels and alignment counts
	// ----------------------------------------
	localparam logic [1:0] FAULT_NONE  = 2'h0;
	localparam logic [1:0] FAULT_MAIN  = 2'h1;
	localparam logic [1:0] FAULT_EOH   = 2'h2;
	localparam logic [1:0] FAULT_BOTH  = 2'h3;
	localparam logic [1:0] ALIGN_GOOD_N = 2'h3;
	localparam logic [1:0] ALIGN_BAD_N  = 2'h2;

	// ----------------------------------------
	// Buffering
	// ----------------------------------------
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned FIFO_DEPTH = 16;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [1:0] tfc_fault_t;

	typedef struct packed {
		logic [15:0] data_size;
		logic [15:0] control_size;
		logic [15:0] payload_length;
		tfc_fault_t  fault;
	} tfc_tx_cfg_s;

	typedef struct packed {
		logic [15:0] data_size;
		logic [15:0] control_size;
		tfc_fault_t  fault;
		logic        fault_valid;
	} tfc_rx_hdr_s;

	typedef enum {ALIGN_HUNT, ALIGN_CONFIRM, ALIGN_LOCKED} tfc_align_e;

endpackage

// ---- logic/tfc_codec.sv ----
// Transport frame codec: builds and parses the 24 ms byte frame.
// Assumes byte-wide link adapters and an external payload CRC checker,
// all on clk_sys_in.
//
// Operation
// - One frame of fixed byte count starts on each 24 ms tick that finds the last frame done.
// - First sent byte is index -8, last is frame_length minus 9.
// - Areas in order: marker header, size header, data, control, tail.
// - Fault byte at -8, then 24-bit frame marker at -7 to -5.
// - Sent fault byte copies the incoming data-layer frame fault level.
// - Fault level is always 0 to 3.
// - CRC fails raise fault: main 1, end-of-header 2, both 3.
// - Receiver never lowers the received fault level.
// - Fault byte is meaningless when data size is zero.
// - Marker alternates 1F90CA and E06F35, sent high byte first.
// - Alignment after three consecutive correctly alternating markers.
// - Alignment lost after two consecutive wrong markers.
// - 16-bit data size sits at indices -4 and -3.
// - 16-bit control size sits at indices -2 and -1.
// - Eight plus both sizes never exceeds frame length.
// - Data size zero means no data area.
// - Control size zero means no control area.
// - Data-layer bytes go unchanged at indices 0 onward.
// - Data area beyond payload length is padded with 55.
// - Control blocks sit back to back after the data area.
// - Bytes after the control area up to frame end are tail padding.
// - Sizes kept constant; receiver flags sizes that change.
// - Tail padding bytes are 55.
`timescale 1ns/1ps

module tfc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	// Drain side
	output logic [WIDTH-1:0]      out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
	assign out_valid_out = cnt_reg != '0;
	assign out_data_out  = mem_reg[rd_ptr_reg];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			cnt_reg    <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module tfc_codec #(
	parameter int unsigned FRAME_CYCLES = tfc_pkg::FRAME_CYCLES,
	parameter logic [15:0] FRAME_LEN    = tfc_pkg::FRAME_LEN_DEF
) (
	// Clock and reset
	input  wire logic               clk_sys_in,
	input  wire logic               rst_n_in,
	// Transmit configuration, sampled at frame start
	input  wire tfc_pkg::tfc_tx_cfg_s tx_cfg_in,
	// Data-layer bytes in
	input  wire logic [7:0]         dl_byte_in,
	input  wire logic               dl_valid_in,
	output logic                    dl_ready_out,
	// Control transport blocks in
	input  wire logic [7:0]         cb_byte_in,
	input  wire logic               cb_valid_in,
	output logic                    cb_ready_out,
	// Link byte stream out
	output logic [7:0]              tx_byte_out,
	output logic                    tx_valid_out,
	output logic                    tx_sof_out,
	input  wire logic               tx_ready_in,
	output logic                    tx_overrun_out,
	// Link byte stream in
	input  wire logic [7:0]         rx_byte_in,
	input  wire logic               rx_valid_in,
	// Payload CRC results
	input  wire logic               crc_valid_in,
	input  wire logic               crc_main_fail_in,
	input  wire logic               crc_eoh_fail_in,
	// Receive status and payload
	output tfc_pkg::tfc_rx_hdr_s    rx_hdr_out,
	output logic                    rx_aligned_out,
	output logic                    rx_size_err_out,
	output logic                    rx_size_change_out,
	output logic [7:0]              rx_byte_out,
	output logic                    rx_data_valid_out,
	output logic                    rx_ctl_valid_out
);
	import tfc_pkg::*;

	// ----------------------------------------
	// Frame timer
	// ----------------------------------------
	logic [31:0] tmr_reg;
	logic        frame_tick;

	assign frame_tick = tmr_reg == 32'(FRAME_CYCLES - 1);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= frame_tick ? '0 : tmr_reg + 32'h1;
		end
	end

	// ----------------------------------------
	// Transmit
	// ----------------------------------------
	tfc_tx_cfg_s tx_cfg_reg;
	logic        tx_active_reg;
	logic [15:0] tx_pos_reg;
	logic        tx_odd_reg;
	logic [7:0]  tx_byte_reg;
	logic        tx_valid_reg;
	logic        tx_sof_reg;
	logic        tx_overrun_reg;
	logic [7:0]  fifo_data;
	logic        fifo_valid;
	logic        fifo_rd;
	logic [15:0] tx_idx;
	logic [15:0] tx_dl_len;
	logic [16:0] tx_area_end;
	logic        tx_in_hdr;
	logic        tx_in_dl;
	logic        tx_in_dpad;
	logic        tx_in_ctl;
	logic        tx_in_tail;
	logic [23:0] tx_marker;
	logic [7:0]  tx_hdr_byte;
	logic [7:0]  tx_byte_next;
	logic        tx_src_ok;
	logic        tx_step;
	logic        tx_last;
	logic        tx_start;

	tfc_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_dl_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_n_in      (rst_n_in),
		.in_data_in    (dl_byte_in),
		.in_valid_in   (dl_valid_in),
		.in_ready_out  (dl_ready_out),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_rd)
	);

	// Area decode over position (index = position - 8)
	assign tx_idx      = tx_pos_reg - HDR_LEN;
	assign tx_area_end = {1'b0, tx_cfg_reg.data_size} + {1'b0, tx_cfg_reg.control_size};
	assign tx_dl_len   = (tx_cfg_reg.payload_length > tx_cfg_reg.data_size) ?
	                     tx_cfg_reg.data_size : tx_cfg_reg.payload_length;
	assign tx_in_hdr   = tx_pos_reg < HDR_LEN;
	assign tx_in_dl    = !tx_in_hdr && tx_idx < tx_dl_len;
	assign tx_in_dpad  = !tx_in_hdr && !tx_in_dl && tx_idx < tx_cfg_reg.data_size;
	assign tx_in_ctl   = !tx_in_hdr && tx_idx >= tx_cfg_reg.data_size &&
	                     {1'b0, tx_idx} < tx_area_end;
	assign tx_in_tail  = !tx_in_hdr && !tx_in_dl && !tx_in_dpad && !tx_in_ctl;
	assign tx_marker   = tx_odd_reg ? MARKER_ODD : MARKER_EVEN;

	always_comb begin
		case (tx_pos_reg[2:0])
			POS_FAULT: tx_hdr_byte = {6'h00, tx_cfg_reg.fault};
			POS_MARK0: tx_hdr_byte = tx_marker[23:16];
			POS_MARK1: tx_hdr_byte = tx_marker[15:8];
			POS_MARK2: tx_hdr_byte = tx_marker[7:0];
			POS_DS_HI: tx_hdr_byte = tx_cfg_reg.data_size[15:8];
			POS_DS_LO: tx_hdr_byte = tx_cfg_reg.data_size[7:0];
			POS_CS_HI: tx_hdr_byte = tx_cfg_reg.control_size[15:8];
			POS_CS_LO: tx_hdr_byte = tx_cfg_reg.control_size[7:0];
			default:   tx_hdr_byte = PAD_BYTE;
		endcase
	end

	assign tx_byte_next = tx_in_hdr ? tx_hdr_byte :
	                      tx_in_dl  ? fifo_data   :
	                      tx_in_ctl ? cb_byte_in  : PAD_BYTE;
	assign tx_src_ok    = tx_in_dl ? fifo_valid : (tx_in_ctl ? cb_valid_in : 1'b1);
	assign tx_step      = tx_active_reg && tx_src_ok && (!tx_valid_reg || tx_ready_in);
	assign tx_last      = tx_pos_reg == FRAME_LEN - 16'h1;
	assign tx_start     = frame_tick && !tx_active_reg;
	assign fifo_rd      = tx_step && tx_in_dl;
	assign cb_ready_out = tx_step && tx_in_ctl;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_active_reg <= 1'b0;
			tx_pos_reg    <= '0;
			tx_odd_reg    <= 1'b1;
			tx_cfg_reg    <= '0;
		end else if (tx_start) begin
			tx_active_reg <= 1'b1;
			tx_pos_reg    <= '0;
			tx_odd_reg    <= !tx_odd_reg;
			tx_cfg_reg    <= tx_cfg_in;
		end else if (tx_step) begin
			tx_active_reg <= !tx_last;
			tx_pos_reg    <= tx_pos_reg + 16'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_byte_reg    <= '0;
			tx_valid_reg   <= 1'b0;
			tx_sof_reg     <= 1'b0;
			tx_overrun_reg <= 1'b0;
		end else begin
			tx_overrun_reg <= frame_tick && tx_active_reg;
			if (tx_step) begin
				tx_byte_reg  <= tx_byte_next;
				tx_sof_reg   <= tx_pos_reg == '0;
				tx_valid_reg <= 1'b1;
			end else if (tx_ready_in) begin
				tx_valid_reg <= 1'b0;
			end
		end
	end

	assign tx_byte_out    = tx_byte_reg;
	assign tx_valid_out   = tx_valid_reg;
	assign tx_sof_out     = tx_sof_reg;
	assign tx_overrun_out = tx_overrun_reg;

	// ----------------------------------------
	// Receive alignment
	// ----------------------------------------
	tfc_align_e  rx_state_reg;
	logic [23:0] rx_sr_reg;
	logic [15:0] rx_pos_reg;
	logic        rx_exp_odd_reg;
	logic [1:0]  rx_good_reg;
	logic [1:0]  rx_bad_reg;
	logic [23:0] rx_win;
	logic        rx_any_mark;
	logic        rx_mark_chk;
	logic        rx_mark_ok;
	logic        rx_hunt_hit;
	logic        rx_locked;
	logic        rx_in_frame;

	assign rx_win      = {rx_sr_reg[15:0], rx_byte_in};
	assign rx_any_mark = rx_win == MARKER_EVEN || rx_win == MARKER_ODD;
	assign rx_in_frame = rx_state_reg != ALIGN_HUNT;
	assign rx_mark_chk = rx_valid_in && rx_in_frame && rx_pos_reg == 16'(POS_MARK2);
	assign rx_mark_ok  = rx_win == (rx_exp_odd_reg ? MARKER_ODD : MARKER_EVEN);
	assign rx_hunt_hit = rx_valid_in && !rx_in_frame && rx_any_mark;
	assign rx_locked   = rx_state_reg == ALIGN_LOCKED;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_sr_reg <= '0;
		end else if (rx_valid_in) begin
			rx_sr_reg <= {rx_sr_reg[15:0], rx_byte_in};
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_pos_reg <= '0;
		end else if (rx_hunt_hit) begin
			rx_pos_reg <= 16'(POS_DS_HI);
		end else if (rx_valid_in && rx_in_frame) begin
			rx_pos_reg <= (rx_pos_reg == FRAME_LEN - 16'h1) ? '0 : rx_pos_reg + 16'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_state_reg   <= ALIGN_HUNT;
			rx_exp_odd_reg <= 1'b0;
			rx_good_reg    <= '0;
			rx_bad_reg     <= '0;
		end else if (rx_hunt_hit) begin
			rx_state_reg   <= ALIGN_CONFIRM;
			rx_exp_odd_reg <= rx_win == MARKER_EVEN;
			rx_good_reg    <= 2'h1;
			rx_bad_reg     <= '0;
		end else if (rx_mark_chk) begin
			rx_exp_odd_reg <= !rx_exp_odd_reg;
			case (rx_state_reg)
				ALIGN_CONFIRM: begin
					rx_good_reg <= rx_good_reg + 2'h1;
					if (!rx_mark_ok) begin
						rx_state_reg <= ALIGN_HUNT;
					end else if (rx_good_reg + 2'h1 == ALIGN_GOOD_N) begin
						rx_state_reg <= ALIGN_LOCKED;
					end
				end
				ALIGN_LOCKED: begin
					rx_bad_reg <= rx_mark_ok ? '0 : rx_bad_reg + 2'h1;
					if (!rx_mark_ok && rx_bad_reg + 2'h1 == ALIGN_BAD_N) begin
						rx_state_reg <= ALIGN_HUNT;
					end
				end
				default: rx_state_reg <= ALIGN_HUNT;
			endcase
		end
	end

	// ----------------------------------------
	// Receive header, fault level and payload
	// ----------------------------------------
	logic [15:0] rx_ds_reg;
	logic [15:0] rx_cs_reg;
	logic [1:0]  rx_fault_reg;
	logic        rx_size_err_reg;
	logic        rx_size_chg_reg;
	logic        rx_ds_chg_reg;
	logic [7:0]  rx_byte_reg;
	logic        rx_dv_reg;
	logic        rx_cv_reg;
	logic [1:0]  rx_fault_cap;
	logic        rx_fault_cap_en;
	logic [1:0]  rx_crc_lvl;
	logic [15:0] rx_ds_new;
	logic [15:0] rx_cs_new;
	logic        rx_cs_done;
	logic [15:0] rx_idx;
	logic [16:0] rx_area_end;
	logic        rx_is_data;
	logic        rx_is_ctl;
	logic        rx_deliver;

	// Out-of-range fault byte saturates to the top level
	assign rx_fault_cap    = (rx_sr_reg[23:18] != '0) ? FAULT_BOTH : rx_sr_reg[17:16];
	assign rx_fault_cap_en = rx_hunt_hit || (rx_mark_chk && rx_mark_ok);
	assign rx_crc_lvl      = (crc_main_fail_in && crc_eoh_fail_in) ? FAULT_BOTH :
	                         crc_eoh_fail_in  ? FAULT_EOH  :
	                         crc_main_fail_in ? FAULT_MAIN : FAULT_NONE;
	assign rx_ds_new   = {rx_sr_reg[7:0], rx_byte_in};
	assign rx_cs_new   = {rx_sr_reg[7:0], rx_byte_in};
	assign rx_cs_done  = rx_valid_in && rx_in_frame && rx_pos_reg == 16'(POS_CS_LO);
	assign rx_idx      = rx_pos_reg - HDR_LEN;
	assign rx_area_end = {1'b0, rx_ds_reg} + {1'b0, rx_cs_reg};
	assign rx_is_data  = rx_pos_reg >= HDR_LEN && rx_idx < rx_ds_reg;
	assign rx_is_ctl   = rx_pos_reg >= HDR_LEN && !rx_is_data && {1'b0, rx_idx} < rx_area_end;
	assign rx_deliver  = rx_valid_in && rx_locked && !rx_size_err_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_fault_reg <= FAULT_NONE;
		end else if (rx_fault_cap_en) begin
			rx_fault_reg <= rx_fault_cap;
		end else if (crc_valid_in && rx_crc_lvl > rx_fault_reg) begin
			rx_fault_reg <= rx_crc_lvl;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_ds_reg       <= '0;
			rx_cs_reg       <= '0;
			rx_size_err_reg <= 1'b0;
			rx_size_chg_reg <= 1'b0;
			rx_ds_chg_reg   <= 1'b0;
		end else begin
			if (rx_valid_in && rx_in_frame && rx_pos_reg == 16'(POS_DS_LO)) begin
				rx_ds_reg     <= rx_ds_new;
				rx_ds_chg_reg <= rx_ds_new != rx_ds_reg;
			end
			if (rx_cs_done) begin
				rx_cs_reg       <= rx_cs_new;
				rx_size_err_reg <= 17'(HDR_LEN) + {1'b0, rx_ds_reg} + {1'b0, rx_cs_new} >
				                   {1'b0, FRAME_LEN};
				rx_size_chg_reg <= rx_cs_new != rx_cs_reg ||
				                   rx_ds_chg_reg;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_byte_reg <= '0;
			rx_dv_reg   <= 1'b0;
			rx_cv_reg   <= 1'b0;
		end else begin
			rx_byte_reg <= rx_valid_in ? rx_byte_in : rx_byte_reg;
			rx_dv_reg   <= rx_deliver && rx_is_data;
			rx_cv_reg   <= rx_deliver && rx_is_ctl;
		end
	end

	assign rx_hdr_out = '{data_size:    rx_ds_reg,
	                      control_size: rx_cs_reg,
	                      fault:        rx_fault_reg,
	                      fault_valid:  rx_ds_reg != '0};
	assign rx_aligned_out          = rx_locked;
	assign rx_size_err_out         = rx_size_err_reg;
	assign rx_size_change_out      = rx_size_chg_reg;
	assign rx_byte_out             = rx_byte_reg;
	assign rx_data_valid_out       = rx_dv_reg;
	assign rx_ctl_valid_out        = rx_cv_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb_chk @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// Previous marker check was a bad one while aligned
	logic mark_bad_prev_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mark_bad_prev_reg <= 1'b0;
		end else if (rx_mark_chk) begin
			mark_bad_prev_reg <= !rx_mark_ok && rx_locked;
		end
	end

	sequence seq_mark_bad;
		rx_mark_chk && !rx_mark_ok && rx_locked;
	endsequence

	sequence seq_mark_good_last;
		rx_mark_chk && rx_mark_ok && rx_state_reg == ALIGN_CONFIRM && rx_good_reg == 2'h2;
	endsequence

	tx_sof_pos_a: assert property (
		tx_step && tx_pos_reg == '0 |=> tx_sof_out && tx_valid_out)
		else $error("Start of frame not flagged on first byte");
	tx_marker_a: assert property (
		tx_step && tx_pos_reg == 16'(POS_MARK0) |=> tx_byte_out == (tx_odd_reg ?
		MARKER_ODD[23:16] : MARKER_EVEN[23:16]))
		else $error("Marker byte wrong");
	tx_data_pad_a: assert property (
		tx_step && tx_in_dpad |=> tx_byte_out == PAD_BYTE)
		else $error("Data area padding wrong");
	tx_tail_pad_a: assert property (
		tx_step && tx_in_tail |=> tx_byte_out == PAD_BYTE)
		else $error("Tail padding wrong");
	tx_frame_end_a: assert property (
		tx_step && tx_last |=> !tx_active_reg && tx_pos_reg == FRAME_LEN)
		else $error("Frame length not kept");
	rx_fault_max_a: assert property (
		crc_valid_in && crc_main_fail_in && crc_eoh_fail_in && !rx_fault_cap_en
		|=> rx_fault_reg == FAULT_BOTH)
		else $error("Fault not raised to top level");
	rx_no_lower_a: assert property (
		!rx_fault_cap_en |=> rx_fault_reg >= $past(rx_fault_reg))
		else $error("Fault level lowered");
	rx_lock_gain_a: assert property (
		seq_mark_good_last |=> rx_locked)
		else $error("Alignment not declared after three markers");
	rx_lock_loss_a: assert property (
		seq_mark_bad ##0 mark_bad_prev_reg |=> !rx_locked)
		else $error("Alignment kept after two bad markers");
	rx_deliver_a: assert property (
		rx_data_valid_out || rx_ctl_valid_out |-> $past(rx_locked))
		else $error("Payload delivered while not aligned");
	rx_size_void_a: assert property (
		rx_size_err_out && $past(rx_size_err_out) |-> !rx_data_valid_out && !rx_ctl_valid_out)
		else $error("Payload delivered with bad sizes");
endmodule

// ---- dv/tfc_link_model.sv ----
// Link adapter model: takes the codec's byte stream and loops it back.
// Assumes the codec's clock and reset; the bench sets pacing and corruption.
`timescale 1ns/1ps

module tfc_link_model (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	// Byte stream from the codec
	input  wire logic [7:0] tx_byte_in,
	input  wire logic       tx_valid_in,
	input  wire logic       tx_sof_in,
	output logic            tx_ready_out,
	// Looped-back stream to the codec
	output logic [7:0]      rx_byte_out,
	output logic            rx_valid_out,
	// Control: slow takes, corrupt 1 = size byte, 2 = marker byte
	input  wire logic       slow_in,
	input  wire logic [1:0] corrupt_in
);
	logic [7:0] pos_reg;
	wire        take = tx_valid_in & tx_ready_out;
	wire  [7:0] pos  = tx_sof_in ? 8'h00 : pos_reg;
	wire  [7:0] sent = (corrupt_in == 2'h1 && pos == 8'h04) ? 8'hff :
	                   (corrupt_in == 2'h2 && pos == 8'h01) ? ~tx_byte_in : tx_byte_in;

	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pos_reg      <= 8'h00;
			tx_ready_out <= 1'b0;
			rx_byte_out  <= 8'h00;
			rx_valid_out <= 1'b0;
		end else begin
			tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
			rx_valid_out <= take;
			// Idle line inverts its byte every cycle
			rx_byte_out  <= take ? sent : ~rx_byte_out;
			if (take)
				pos_reg <= pos + 8'h01;
		end
	end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench of the transport frame codec.
// Assumes the link model loops the sent stream back into the receiver.
`timescale 1ns/1ps

module tb_top;
	import tfc_pkg::*;
	localparam int          FC = 200;
	localparam logic [15:0] FL = 16'h0020;
	typedef struct packed {
		tfc_tx_cfg_s cfg;
		logic [7:0]  nd;
		logic [7:0]  nc;
		logic        al;
	} tfc_row_s;
	// Sizes fit the frame and stay put per row; nd ff skips the delivery count
	tfc_row_s rows [5] = '{
		'{'{16'h0008, 16'h0004, 16'h0005, 2'h1}, 8'h00, 8'h00, 1'b0},
		'{'{16'h0000, 16'h0006, 16'h0000, 2'h3}, 8'h00, 8'h00, 1'b0},
		'{'{16'h000a, 16'h0000, 16'h000a, 2'h2}, 8'h0a, 8'h00, 1'b1},
		'{'{16'h0000, 16'h0000, 16'h0000, 2'h0}, 8'h00, 8'h00, 1'b1},
		'{'{16'h0014, 16'h0004, 16'h0014, 2'h0}, 8'h14, 8'h04, 1'b1}};
	logic clk_sys_in = 1'b0, rst_n_in = 1'b0, dl_valid = 1'b0, cb_valid = 1'b0;
	logic crc_v = 1'b0, crc_m = 1'b0, crc_e = 1'b0, slow = 1'b0;
	logic [1:0] corrupt = 2'h0;
	logic [7:0] dl_byte = 8'h00, cb_byte = 8'h00, exp_dl = 8'h00, exp_cb = 8'h00;
	logic [7:0] tx_byte, rx_byte, rx_out, nd = 8'h00, nc = 8'h00, e;
	logic dl_ready, cb_ready, tx_valid, tx_sof, tx_ready, rx_valid;
	logic aligned, size_err, size_chg, rxd_v, rxc_v, overrun;
	logic [15:0] hist = 16'h0000;
	logic [4:0] crc_m_seq = 5'b01101, crc_e_seq = 5'b01010;
	logic [15:0] ds, cs, pl;
	tfc_rx_hdr_s hdr;
	tfc_row_s cur = '0;
	int error_cnt = 0, checks_done = 0, pos = 0, frames = 0, d, ovr_n = 0;

	tfc_codec #(.FRAME_CYCLES(FC), .FRAME_LEN(FL)) u_dut (.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .tx_cfg_in(cur.cfg), .dl_byte_in(dl_byte),
		.dl_valid_in(dl_valid), .dl_ready_out(dl_ready), .cb_byte_in(cb_byte),
		.cb_valid_in(cb_valid), .cb_ready_out(cb_ready), .tx_byte_out(tx_byte),
		.tx_valid_out(tx_valid), .tx_sof_out(tx_sof), .tx_ready_in(tx_ready),
		.tx_overrun_out(overrun), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
		.crc_valid_in(crc_v), .crc_main_fail_in(crc_m), .crc_eoh_fail_in(crc_e),
		.rx_hdr_out(hdr), .rx_aligned_out(aligned), .rx_size_err_out(size_err),
		.rx_size_change_out(size_chg), .rx_byte_out(rx_out),
		.rx_data_valid_out(rxd_v), .rx_ctl_valid_out(rxc_v));

	tfc_link_model u_link (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .tx_sof_in(tx_sof),
		.tx_ready_out(tx_ready), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
		.slow_in(slow), .corrupt_in(corrupt));

	initial begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_frame();
		int f = frames;
		int n = 0;
		while (frames == f && n < 1000) begin
			@(posedge clk_sys_in);
			n++;
		end
		repeat (5) @(posedge clk_sys_in);
		if (frames == f) begin
			error_cnt++;
			$display("MISMATCH frame end expected done seen timeout");
			conclude();
		end
	endtask

	// ----------------------------------------
	// Sources and sent-frame checker
	// ----------------------------------------
	always @(posedge clk_sys_in) begin
		if (dl_valid && dl_ready)
			dl_byte <= dl_byte + 8'h01;
		if (cb_valid && cb_ready)
			cb_byte <= cb_byte + 8'h01;
	end

	always @(posedge clk_sys_in) begin
		ds = cur.cfg.data_size;
		cs = cur.cfg.control_size;
		pl = (cur.cfg.payload_length < ds) ? cur.cfg.payload_length : ds;
		if (tx_valid && tx_ready) begin
			if (tx_sof) begin
				pos = 0;
				nd = 8'h00;
				nc = 8'h00;
			end
			d = pos - 8;
			if (pos == 0)
				e = {6'h00, cur.cfg.fault};
			else if (pos < 4)
				e = frames[0] ? MARKER_ODD[8*(3-pos) +: 8] : MARKER_EVEN[8*(3-pos) +: 8];
			else if (pos < 8)
				e = (pos < 6) ? ds[8*(5-pos) +: 8] : cs[8*(7-pos) +: 8];
			else if (d < pl) begin
				e = exp_dl;
				exp_dl = exp_dl + 8'h01;
			end else if (d < ds)
				e = PAD_BYTE;
			else if (d < ds + cs) begin
				e = exp_cb;
				exp_cb = exp_cb + 8'h01;
			end else
				e = PAD_BYTE;
			check("tx byte", tx_byte, e);
			if (pos == FL - 1)
				frames++;
			pos++;
		end
		if (rxd_v || rxc_v)
			check("rx byte", rx_out, hist[15:8]);
		hist = {hist[7:0], tx_byte};
		if (overrun)
			ovr_n++;
		if (rxd_v)
			nd++;
		if (rxc_v)
			nc++;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tfc_tx_cfg_s c;
		repeat (4) @(posedge clk_sys_in);
		check("reset outputs", {dl_ready, tx_valid, aligned, hdr}, {3'b100, 35'h0});
		rst_n_in <= 1'b1;
		dl_valid <= 1'b1;
		cb_valid <= 1'b1;
		$display("reset test done");
		for (int i = 0; i < 5; i++) begin
			c = rows[i].cfg;
			cur <= rows[i];
			slow <= i[0];
			wait_frame();
			if (rows[i].nd != 8'hff)
				check("deliveries", {nd, nc}, {rows[i].nd, rows[i].nc});
			check("aligned", aligned, rows[i].al);
			if (rows[i].al)
				check("header", hdr, {c.data_size, c.control_size, c.fault, c.data_size != 0});
			$display("row %0d done", i);
		end
		// Main, end-of-header, main again, both, none
		for (int i = 0; i < 5; i++) begin
			crc_v <= 1'b1;
			crc_m <= crc_m_seq[i];
			crc_e <= crc_e_seq[i];
			@(posedge clk_sys_in);
			crc_v <= 1'b0;
			repeat (2) @(posedge clk_sys_in);
			check("fault", hdr.fault, 10'h3e9 >> (2 * i) & 10'h3);
		end
		$display("crc test done");
		corrupt <= 2'h1;
		wait_frame();
		check("size flags", {size_err, size_chg, nd}, {2'b11, 8'h00});
		$display("size test done");
		corrupt <= 2'h2;
		wait_frame();
		check("aligned one bad", aligned, 1'b1);
		wait_frame();
		check("aligned two bad", aligned, 1'b0);
		$display("marker test done");
		// Stalled control source keeps a frame open across the next tick
		check("overrun idle", ovr_n, 0);
		cb_valid <= 1'b0;
		repeat (450) @(posedge clk_sys_in);
		check("overrun stall", ovr_n != 0, 1'b1);
		cb_valid <= 1'b1;
		$display("overrun test done");
		conclude();
	end
endmodule
